//--- src/cas_alert_status.sv
/*
  Sticky threshold alert flags for analog channels 4..7 behind an AXI4-Lite
  slave, with auto-clear by hysteresis, read-to-clear and a masked interrupt.
  Assumes conversion results, thresholds and hysteresis widths arrive
  synchronous to sys_clk from the converter datapath and threshold registers.
*/
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - result at or below lower threshold sets low flag
// - result at or above upper threshold sets high flag
// - flags set or auto-clear only with detection enabled
// - reading status returns flags then clears them
// - auto-clear mode clears flag when back in range by more than the hysteresis width
// - channel 7 low bit 7, high bit 6
// - channel 6 low bit 5, high bit 4
// - channel 5 low bit 3, high bit 2
// - channel 4 low bit 1, high bit 0
// - status at index 0x16, resets to zero
// - channels 8..11 status at index 0x17, zero
module cas_alert_status #(
  parameter int ADDR_W = 8,
  parameter int RES_W = 16,
  parameter int HYST_W = 7
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic convValid,
  input wire logic [3:0] convChannel,
  input wire logic [RES_W-1:0] convResult,
  input wire logic [cas_pkg::NUM_CH*RES_W-1:0] lowThreshold,
  input wire logic [cas_pkg::NUM_CH*RES_W-1:0] highThreshold,
  input wire logic [cas_pkg::NUM_CH*HYST_W-1:0] hysteresisWidth,
  output logic irq
);
  import cas_pkg::*;

  if (ADDR_W < 8 || RES_W < 2 || RES_W > 31 || HYST_W < 1 || HYST_W > RES_W) begin : g_bad_params
    $error("cas_alert_status: unsupported parameter values");
  end

  logic [FLAG_W-1:0] alertFlags;
  logic [FLAG_W-1:0] alertCh8Ch11;
  logic [FLAG_W-1:0] next_alertFlags;
  logic [FLAG_W-1:0] alertEvents;
  logic [FLAG_W-1:0] irqStatus;
  logic [FLAG_W-1:0] irqMask;
  logic [NUM_CH-1:0] detectEnable;
  logic autoClearMode;

  logic awHave;
  logic wHave;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic next_awHave;
  logic next_wHave;
  logic doWrite;
  logic [7:0] wrIdx;
  logic wrMapped;
  logic arTaken;
  logic [7:0] rdIdx;
  logic readClear;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // ---------------- write channel ----------------
  assign next_awHave = (awHave && !doWrite) || (s_axi_awvalid && s_axi_awready);
  assign next_wHave = (wHave && !doWrite) || (s_axi_wvalid && s_axi_wready);
  assign doWrite = awHave && wHave && !s_axi_bvalid;
  assign wrIdx = 8'(awAddr[ADDR_W-1:2]);
  assign wrMapped = (wrIdx == IDX_ALERT_CH4_CH7) || (wrIdx == IDX_ALERT_CH8_CH11) ||
                    (wrIdx == IDX_SETUP) || (wrIdx == IDX_IRQ_STATUS) || (wrIdx == IDX_IRQ_MASK);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      awHave <= next_awHave;
      wHave <= next_wHave;
      s_axi_awready <= !next_awHave;
      s_axi_wready <= !next_wHave;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awAddr <= '0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // setup: per-channel detection enables and auto-clear selection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      detectEnable <= SETUP_EN_RESET;
      autoClearMode <= SETUP_AUTOCLR_RESET;
    end else if (doWrite && wrIdx == IDX_SETUP) begin
      if (wStrb[0]) begin
        detectEnable <= wData[SETUP_EN_LSB +: NUM_CH];
      end
      if (wStrb[1]) begin
        autoClearMode <= wData[SETUP_AUTOCLR_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqMask <= IRQ_MASK_RESET;
    end else if (doWrite && wrIdx == IDX_IRQ_MASK && wStrb[0]) begin
      irqMask <= wData[FLAG_W-1:0];
    end
  end

  // interrupt status: set by alert events, write one to clear; set wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqStatus <= ALERT_RESET;
    end else if (doWrite && wrIdx == IDX_IRQ_STATUS && wStrb[0]) begin
      irqStatus <= (irqStatus & ~wData[FLAG_W-1:0]) | alertEvents;
    end else begin
      irqStatus <= irqStatus | alertEvents;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // ---------------- read channel ----------------
  assign arTaken = s_axi_arvalid && s_axi_arready;
  assign rdIdx = 8'(s_axi_araddr[ADDR_W-1:2]);
  assign readClear = arTaken && (rdIdx == IDX_ALERT_CH4_CH7);
  assign next_rvalid = (s_axi_rvalid && !s_axi_rready) || arTaken;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = RESP_OKAY;
    unique case (rdIdx)
      IDX_ALERT_CH4_CH7: next_rdata[FLAG_W-1:0] = alertFlags;
      IDX_ALERT_CH8_CH11: next_rdata[FLAG_W-1:0] = alertCh8Ch11;
      IDX_SETUP: begin
        next_rdata[SETUP_EN_LSB +: NUM_CH] = detectEnable;
        next_rdata[SETUP_AUTOCLR_BIT] = autoClearMode;
      end
      IDX_IRQ_STATUS: next_rdata[FLAG_W-1:0] = irqStatus;
      IDX_IRQ_MASK: next_rdata[FLAG_W-1:0] = irqMask;
      default: next_rresp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= !next_rvalid;
      if (arTaken) begin
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end
    end
  end

  // channels 8..11 live elsewhere; this word only decodes and reads zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alertCh8Ch11 <= ALERT_CH8_CH11_RESET;
    end else begin
      alertCh8Ch11 <= ALERT_CH8_CH11_RESET;
    end
  end

  // ---------------- alert flags ----------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam int LO = 2 * c + LOW_BIT_OFS;
    localparam int HI = 2 * c + HIGH_BIT_OFS;
    logic hit;
    logic lowSet;
    logic highSet;
    logic lowBack;
    logic highBack;
    logic [RES_W-1:0] lowThr;
    logic [RES_W-1:0] highThr;
    logic [RES_W:0] hyst;

    assign lowThr = lowThreshold[c*RES_W +: RES_W];
    assign highThr = highThreshold[c*RES_W +: RES_W];
    assign hyst = (RES_W+1)'(hysteresisWidth[c*HYST_W +: HYST_W]);
    assign hit = convValid && convChannel == 4'(FIRST_CH + c) && detectEnable[c];
    assign lowSet = hit && convResult <= lowThr;
    assign highSet = hit && convResult >= highThr;
    // back inside the band by more than the hysteresis width
    assign lowBack = hit && autoClearMode && ({1'b0, convResult} > {1'b0, lowThr} + hyst);
    assign highBack = hit && autoClearMode && ({1'b0, convResult} + hyst < {1'b0, highThr});
    // bit placement per channel
    assign alertEvents[LO] = lowSet;
    assign alertEvents[HI] = highSet;
    assign next_alertFlags[LO] = lowSet || (alertFlags[LO] && !readClear && !lowBack);
    assign next_alertFlags[HI] = highSet || (alertFlags[HI] && !readClear && !highBack);

    property p_low_set;
      @(posedge sys_clk) disable iff (rst)
        (convValid && convChannel == 4'(FIRST_CH + c) && detectEnable[c] && convResult <= lowThr)
        |=> alertFlags[2 * c + 1];
    endproperty
    a_low_set: assert property (p_low_set) else $error("low alert flag not set");

    property p_high_set;
      @(posedge sys_clk) disable iff (rst)
        (convValid && convChannel == 4'(FIRST_CH + c) && detectEnable[c] && convResult >= highThr)
        |=> alertFlags[2 * c];
    endproperty
    a_high_set: assert property (p_high_set) else $error("high alert flag not set");

    property p_disabled_quiet;
      @(posedge sys_clk) disable iff (rst)
        (!detectEnable[c] && alertFlags[2 * c +: 2] == 2'h0) |=> alertFlags[2 * c +: 2] == 2'h0;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("flag set while disabled");

    property p_auto_clear;
      @(posedge sys_clk) disable iff (rst)
        (autoClearMode && convValid && convChannel == 4'(FIRST_CH + c) && detectEnable[c] &&
         convResult > lowThr && {1'b0, convResult} > {1'b0, lowThr} + hyst)
        |=> !alertFlags[2 * c + 1];
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("low flag not auto-cleared");

    property p_auto_clear_high;
      @(posedge sys_clk) disable iff (rst)
        (autoClearMode && convValid && convChannel == 4'(FIRST_CH + c) && detectEnable[c] &&
         {1'b0, convResult} + hyst < {1'b0, highThr})
        |=> !alertFlags[2 * c];
    endproperty
    a_auto_clear_high: assert property (p_auto_clear_high) else $error("high flag not auto-cleared");
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alertFlags <= ALERT_RESET;
    end else begin
      alertFlags <= next_alertFlags;
    end
  end

  property p_read_clear;
    @(posedge sys_clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready && rdIdx == IDX_ALERT_CH4_CH7 && alertEvents == 8'h00)
      |=> (s_axi_rvalid && s_axi_rdata[7:0] == $past(alertFlags) && alertFlags == 8'h00);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not return and clear");

  property p_reset_zero;
    @(posedge sys_clk) rst |=> (alertFlags == 8'h00 && irqStatus == 8'h00 && !irq);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("flags not zero after reset");

  property p_ch8_zero;
    @(posedge sys_clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready && rdIdx == IDX_ALERT_CH8_CH11)
      |=> (s_axi_rdata == 32'h0000_0000 && s_axi_rresp == RESP_OKAY);
  endproperty
  a_ch8_zero: assert property (p_ch8_zero) else $error("channel 8..11 word not zero");

  property p_set_beats_read;
    @(posedge sys_clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready && rdIdx == IDX_ALERT_CH4_CH7 && alertEvents != 8'h00)
      |=> ((alertFlags & $past(alertEvents)) == $past(alertEvents));
  endproperty
  a_set_beats_read: assert property (p_set_beats_read) else $error("event lost in clearing read");

  property p_irq_level;
    @(posedge sys_clk) disable iff (rst)
      1'b1 |=> (irq == $past(|(irqStatus & irqMask)));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");
endmodule

//--- shared/cas_pkg.sv
/*
  Constants for the channel 4..7 alert status bank: register indices,
  field positions, reset values and bus response codes.
  Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
*/
package cas_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ALERT_CH4_CH7 = 8'h16;
  localparam logic [7:0] IDX_ALERT_CH8_CH11 = 8'h17;
  localparam logic [7:0] IDX_SETUP = 8'h20;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h21;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h22;

  localparam int NUM_CH = 4;
  localparam int FIRST_CH = 4;
  localparam int FLAG_W = 8;
  localparam logic [7:0] ALERT_RESET = 8'h00;
  localparam logic [7:0] ALERT_CH8_CH11_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

  // per channel c (0 = ch4): lower flag bit 2c+1, upper flag bit 2c
  localparam int LOW_BIT_OFS = 1;
  localparam int HIGH_BIT_OFS = 0;

  // setup register fields
  localparam int SETUP_EN_LSB = 0;
  localparam int SETUP_AUTOCLR_BIT = 8;
  localparam logic [3:0] SETUP_EN_RESET = 4'h0;
  localparam logic SETUP_AUTOCLR_RESET = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- test/cas_host_model.sv
/*
  AXI4-Lite host model that issues one write or one read at a time.
  Assumes the bench calls its tasks from one process at a time and that
  sys_clk is the slave's clock.
*/
`timescale 1ns/1ps
module cas_host_model (
  input wire logic sys_clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      // released address and data lines show a changed value, never the old one
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
endmodule

//--- test/cas_alert_status_tb.sv
/*
  Self-checking bench for the channel 4..7 alert status bank.
  Assumes the host model drives the register bus and the bench drives conversions.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errorCnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module cas_alert_status_tb;
  import cas_pkg::*;
  localparam logic [7:0] A_ST = IDX_ALERT_CH4_CH7 << 2;
  localparam logic [7:0] A_ST8 = IDX_ALERT_CH8_CH11 << 2;
  localparam logic [7:0] A_SETUP = IDX_SETUP << 2;
  localparam logic [7:0] A_IRQST = IDX_IRQ_STATUS << 2;
  localparam logic [7:0] A_MASK = IDX_IRQ_MASK << 2;
  logic sysClk, rst, convValid, irq;
  logic [3:0] convChannel;
  logic [15:0] convResult;
  logic [63:0] lowThreshold, highThreshold;
  logic [27:0] hysteresisWidth;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int errorCnt, nCompared, cycles;
  cas_alert_status u_cas_alert_status (.sys_clk(sysClk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .convValid(convValid),
    .convChannel(convChannel), .convResult(convResult), .lowThreshold(lowThreshold),
    .highThreshold(highThreshold), .hysteresisWidth(hysteresisWidth), .irq(irq));
  cas_host_model u_cas_host_model (.sys_clk(sysClk), .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid), .awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid), .wready(s_axi_wready), .bresp(s_axi_bresp), .bvalid(s_axi_bvalid),
    .bready(s_axi_bready), .araddr(s_axi_araddr), .arvalid(s_axi_arvalid),
    .arready(s_axi_arready), .rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid),
    .rready(s_axi_rready));
  initial begin
    sysClk = 1'b0;
    forever #25 sysClk = ~sysClk;
  end
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 20000) begin
      errorCnt++;
      tally_and_finish();
    end
  end
  function automatic logic [15:0] lo(input int c);
    return 16'h1000 + 16'(c * 256);
  endfunction
  function automatic logic [15:0] hi(input int c);
    return 16'hF000 + 16'(c * 256);
  endfunction
  task automatic conv(input int ch, input logic [15:0] v);
    @(posedge sysClk);
    convValid <= 1'b1;
    convChannel <= 4'(ch);
    convResult <= v;
    @(posedge sysClk);
    convValid <= 1'b0;
    convResult <= ~v;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    u_cas_host_model.rd(a, rd, rsp);
    `CHK({rsp, rd}, {RESP_OKAY, 24'h0, e})
  endtask
  task automatic wrOk(input logic [7:0] a, input logic [31:0] d);
    u_cas_host_model.wr(a, d, rsp);
    `CHK(rsp, RESP_OKAY)
  endtask
  task automatic irqChk(input logic e);
    repeat (2) @(posedge sysClk);
    #1;
    `CHK(irq, e)
  endtask
  task automatic t_reset();
    rdChk(A_ST, 8'h00);
    rdChk(A_ST8, 8'h00);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_map();
    wrOk(A_SETUP, 32'h0000000F);
    for (int c = 0; c < 4; c++) begin
      conv(4 + c, lo(c));
      rdChk(A_ST, 8'h01 << (2 * c + 1));
      conv(4 + c, hi(c));
      rdChk(A_ST, 8'h01 << (2 * c));
      conv(4 + c, lo(c) + 16'h1);
      conv(4 + c, hi(c) - 16'h1);
      rdChk(A_ST, 8'h00);
    end
    wrOk(A_ST, 32'h000000FF);
    rdChk(A_ST, 8'h00);
  endtask
  task automatic t_disable();
    wrOk(A_SETUP, 32'h00000001);
    conv(5, lo(1));
    conv(7, hi(3));
    conv(9, 16'h0000);
    rdChk(A_ST, 8'h00);
    conv(4, lo(0));
    rdChk(A_ST, 8'h02);
  endtask
  task automatic t_autoclr();
    wrOk(A_SETUP, 32'h0000010F);
    conv(6, lo(2));
    conv(6, lo(2) + 16'h12);
    rdChk(A_ST, 8'h20);
    conv(6, lo(2));
    conv(6, lo(2) + 16'h13);
    conv(7, hi(3));
    conv(7, hi(3) - 16'h14);
    rdChk(A_ST, 8'h00);
  endtask
  task automatic t_race();
    wrOk(A_SETUP, 32'h0000000F);
    fork
      rdChk(A_ST, 8'h00);
      conv(6, hi(2));
    join
    rdChk(A_ST, 8'h10);
  endtask
  task automatic t_irq();
    wrOk(A_IRQST, 32'h000000FF);
    wrOk(A_MASK, 32'h00000002);
    conv(4, hi(0));
    irqChk(1'b0);
    conv(4, lo(0));
    irqChk(1'b1);
    rdChk(A_IRQST, 8'h03);
    wrOk(A_IRQST, 32'h00000002);
    irqChk(1'b0);
    rdChk(A_IRQST, 8'h01);
    u_cas_host_model.rd(8'h40, rd, rsp);
    `CHK({rsp, rd}, {RESP_SLVERR, 32'h0})
    u_cas_host_model.wr(8'h40, 32'h1, rsp);
    `CHK(rsp, RESP_SLVERR)
  endtask
  task automatic t_midreset();
    conv(5, lo(1));
    @(posedge sysClk);
    rst <= 1'b1;
    repeat (2) @(posedge sysClk);
    rst <= 1'b0;
    @(posedge sysClk);
    rdChk(A_ST, 8'h00);
    rdChk(A_SETUP, 8'h00);
    `CHK(irq, 1'b0)
  endtask
  task automatic tally_and_finish();
    if (errorCnt == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    convValid = 1'b0;
    convChannel = 4'h0;
    convResult = 16'h0000;
    lowThreshold = {16'h1300, 16'h1200, 16'h1100, 16'h1000};
    highThreshold = {16'hF300, 16'hF200, 16'hF100, 16'hF000};
    hysteresisWidth = {7'h13, 7'h12, 7'h11, 7'h10};
    repeat (16) @(posedge sysClk);
    rst <= 1'b0;
    @(posedge sysClk);
    t_reset();
    t_map();
    t_disable();
    t_autoclr();
    t_race();
    t_irq();
    t_midreset();
    tally_and_finish();
  end
endmodule
